/* common/plc_ds_if.sv */
// carrier between the register bank and the speed downshift sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface plc_ds_if;
  logic [2:0] attempts;
  logic [1:0] mode;
  logic neg_fail;
  logic link_lost;
  logic link_enable;
  plc_pkg::plc_speed_t speed;

  modport ctl (output attempts, output mode, output neg_fail, output link_lost,
    output link_enable, input speed);
  modport ds (input attempts, input mode, input neg_fail, input link_lost,
    input link_enable, output speed);
endinterface

/* common/plc_pkg.sv */
// constants, field layout, reset values and types of the link control register
// assumes a 16-bit management register reached over a two-wire serial frame
package plc_pkg;

  // management frame
  localparam logic [4:0] REG_ADDR = 5'h17;
  localparam logic [4:0] PHY_ADDR_DFLT = 5'h01;
  localparam int unsigned DATA_W = 16;
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0c;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;

  // field positions
  localparam int unsigned F_PHONE_DET = 15;
  localparam int unsigned F_PD_EN = 14;
  localparam int unsigned F_LINK_EN = 13;
  localparam int unsigned F_ATT_HI = 12;
  localparam int unsigned F_ATT_LO = 10;
  localparam int unsigned F_PARTNER = 7;
  localparam int unsigned F_JABBER = 6;
  localparam int unsigned F_HEARTBEAT = 5;
  localparam int unsigned F_TP_ECHO = 4;
  localparam int unsigned F_PRE_HI = 3;
  localparam int unsigned F_PRE_LO = 2;
  localparam int unsigned F_FORCE = 0;

  // reset values
  localparam logic RST_PD_EN = 1'b0;
  localparam logic RST_LINK_EN = 1'b1;
  localparam logic [2:0] RST_ATT = 3'h4;
  localparam logic RST_JABBER = 1'b1;
  localparam logic RST_HEARTBEAT = 1'b0;
  localparam logic RST_TP_ECHO = 1'b0;
  localparam logic [1:0] RST_PRE = 2'h2;
  localparam logic RST_FORCE = 1'b0;

  // downshift mode bits
  localparam int unsigned DS_MODE_100 = 1;
  localparam int unsigned DS_MODE_10 = 0;

  typedef enum logic [2:0] {
    PLC_PRE = 3'h0,
    PLC_HDR = 3'h1,
    PLC_TA = 3'h3,
    PLC_RDATA = 3'h2,
    PLC_WDATA = 3'h6
  } plc_mdio_state_t;

  typedef enum logic [1:0] {
    PLC_SPD_1000 = 2'h0,
    PLC_SPD_100 = 2'h1,
    PLC_SPD_10 = 2'h3
  } plc_speed_t;

  // 10 Mb/s preamble length in bytes
  function automatic logic [2:0] pre_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: pre_bytes = 3'h0;
      2'h1: pre_bytes = 3'h1;
      2'h2: pre_bytes = 3'h2;
      2'h3: pre_bytes = 3'h7;
    endcase
  endfunction

endpackage

/* hdl/plc_downshift.sv */
// speed downshift sequencer: 1000 -> 100 -> 10 -> 1000 after repeated failures
// assumes one-cycle neg_fail and link_lost pulses from the negotiation logic
`timescale 1ns/1ps
module plc_downshift (
  input wire logic clock,
  input wire logic reset,
  plc_ds_if.ds bus
);
  typedef struct packed {
    plc_pkg::plc_speed_t speed;
    logic [2:0] fails;
  } plc_ds_st_t;

  plc_ds_st_t st_r;
  plc_ds_st_t st_nxt;

  function automatic plc_pkg::plc_speed_t next_speed(input plc_pkg::plc_speed_t cur,
    input logic [1:0] mode);
    next_speed = plc_pkg::PLC_SPD_1000;
    if (cur == plc_pkg::PLC_SPD_1000 && mode[plc_pkg::DS_MODE_100]) begin
      next_speed = plc_pkg::PLC_SPD_100;
    end else if (cur != plc_pkg::PLC_SPD_10 && mode[plc_pkg::DS_MODE_10]) begin
      next_speed = plc_pkg::PLC_SPD_10;
    end
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (!bus.link_enable || bus.link_lost) begin
      // restart from the top speed on any link loss
      st_nxt.speed = plc_pkg::PLC_SPD_1000;
      st_nxt.fails = 3'h0;
    end else if (bus.neg_fail) begin
      if (st_r.fails == bus.attempts) begin
        st_nxt.speed = next_speed(st_r.speed, bus.mode);
        st_nxt.fails = 3'h0;
      end else begin
        st_nxt.fails = st_r.fails + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '{speed: plc_pkg::PLC_SPD_1000, fails: 3'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.speed = st_r.speed;

  chk_ds_restart: assert property (@(posedge clock) disable iff (reset)
    bus.link_lost |=> bus.speed == plc_pkg::PLC_SPD_1000)
    else $error("speed not back at top after link loss");

  chk_ds_step_down: assert property (@(posedge clock) disable iff (reset)
    (bus.link_enable && !bus.link_lost && bus.neg_fail && st_r.fails == bus.attempts
     && st_r.speed == plc_pkg::PLC_SPD_1000 && bus.mode[plc_pkg::DS_MODE_100])
    |=> bus.speed == plc_pkg::PLC_SPD_100)
    else $error("no step down after configured failures");
endmodule

/* hdl/plc_sync.sv */
// three-stage pin synchroniser; a change counts once stages two and three agree
// assumes inputs are asynchronous to clock
`timescale 1ns/1ps
module plc_sync #(
  parameter int unsigned W = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } plc_sync_st_t;

  plc_sync_st_t st_r;
  plc_sync_st_t st_nxt;

  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.q);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;
endmodule

/* hdl/plc_top.sv */
// link control register at management address 23 with its serial frame engine
// assumes mdc at most clock/16, management pins asynchronous to clock
`timescale 1ns/1ps
module plc_top #(
  parameter logic [4:0] PHY_ADDR = plc_pkg::PHY_ADDR_DFLT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic phone_detect_in,
  input wire logic partner_detect_in,
  input wire logic irq_pending,
  input wire logic neg_fail,
  input wire logic link_lost,
  input wire logic [1:0] downshift_mode,
  output logic link_enable,
  output logic standby,
  output logic link_pulse_watch,
  output logic phone_detect_start,
  output logic cable_reflectometry_avail,
  output logic [3:0] downshift_attempts,
  output logic [1:0] speed_sel,
  output logic jabber_enable,
  output logic heartbeat_enable,
  output logic twisted_pair_echo_disable,
  output logic [2:0] preamble_bytes,
  output logic mgmt_irq_n
);
  typedef struct packed {
    plc_pkg::plc_mdio_state_t st;
    logic [5:0] ones;
    logic [4:0] bcnt;
    logic [15:0] sh;
    logic hit;
    logic is_rd;
    logic wr_stb;
    logic mdo;
    logic oe;
    logic mdc_d;
    logic pd_en;
    logic link_en;
    logic [2:0] att;
    logic partner;
    logic jab_dis;
    logic hb_en;
    logic tp_dis;
    logic [1:0] pre;
    logic force_irq;
    logic phone_det;
    logic pd_active;
    logic pd_start;
  } plc_top_st_t;

  localparam plc_top_st_t RST = '{
    st: plc_pkg::PLC_PRE,
    ones: 6'h00,
    bcnt: 5'h00,
    sh: 16'h0000,
    hit: 1'b0,
    is_rd: 1'b0,
    wr_stb: 1'b0,
    mdo: 1'b0,
    oe: 1'b0,
    mdc_d: 1'b0,
    pd_en: plc_pkg::RST_PD_EN,
    link_en: plc_pkg::RST_LINK_EN,
    att: plc_pkg::RST_ATT,
    partner: 1'b0,
    jab_dis: plc_pkg::RST_JABBER,
    hb_en: plc_pkg::RST_HEARTBEAT,
    tp_dis: plc_pkg::RST_TP_ECHO,
    pre: plc_pkg::RST_PRE,
    force_irq: plc_pkg::RST_FORCE,
    phone_det: 1'b0,
    pd_active: 1'b0,
    pd_start: 1'b0
  };

  plc_top_st_t st_r;
  plc_top_st_t st_nxt;

  logic [3:0] pin_f;
  logic mdc_f;
  logic mdio_f;
  logic phone_f;
  logic partner_f;
  logic mdc_rise;
  logic rd_pulse;
  logic partner_set;
  logic [12:0] hdr;
  logic [15:0] rd_word;

  plc_ds_if u_dsif ();

  plc_sync #(
    .W(4)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .din({mdc, mdio_in, phone_detect_in, partner_detect_in}),
    .dout(pin_f)
  );

  plc_downshift u_ds (
    .clock(clock),
    .reset(reset),
    .bus(u_dsif.ds)
  );

  assign mdc_f = pin_f[3];
  assign mdio_f = pin_f[2];
  assign phone_f = pin_f[1];
  assign partner_f = pin_f[0];
  assign mdc_rise = mdc_f & ~st_r.mdc_d;
  assign hdr = {st_r.sh[11:0], mdio_f};
  assign rd_pulse = mdc_rise && st_r.st == plc_pkg::PLC_TA && st_r.bcnt == 5'h00
    && st_r.is_rd && st_r.hit;
  // partner watch only runs with linking off
  assign partner_set = ~st_r.link_en & partner_f;

  // read value; reserved and unlisted positions stay zero
  always_comb begin
    rd_word = 16'h0000;
    rd_word[plc_pkg::F_PHONE_DET] = st_r.phone_det & ~st_r.link_en & st_r.pd_en;
    rd_word[plc_pkg::F_PD_EN] = st_r.pd_en;
    rd_word[plc_pkg::F_LINK_EN] = st_r.link_en;
    rd_word[plc_pkg::F_ATT_HI:plc_pkg::F_ATT_LO] = st_r.att;
    rd_word[plc_pkg::F_PARTNER] = st_r.partner;
    rd_word[plc_pkg::F_JABBER] = st_r.jab_dis;
    rd_word[plc_pkg::F_HEARTBEAT] = st_r.hb_en;
    rd_word[plc_pkg::F_TP_ECHO] = st_r.tp_dis;
    rd_word[plc_pkg::F_PRE_HI:plc_pkg::F_PRE_LO] = st_r.pre;
    rd_word[plc_pkg::F_FORCE] = st_r.force_irq;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.mdc_d = mdc_f;
    st_nxt.wr_stb = 1'b0;
    // serial frame engine, advances once per mdc rising edge
    if (mdc_rise) begin
      unique case (st_r.st)
        plc_pkg::PLC_PRE: begin
          if (mdio_f) begin
            if (st_r.ones != plc_pkg::PRE_ONES) begin
              st_nxt.ones = st_r.ones + 6'h01;
            end
          end else begin
            // first start bit after a full preamble
            if (st_r.ones == plc_pkg::PRE_ONES) begin
              st_nxt.st = plc_pkg::PLC_HDR;
              st_nxt.bcnt = 5'h00;
            end
            st_nxt.ones = 6'h00;
          end
        end
        plc_pkg::PLC_HDR: begin
          st_nxt.sh = {st_r.sh[14:0], mdio_f};
          if (st_r.bcnt == plc_pkg::HDR_LAST) begin
            st_nxt.bcnt = 5'h00;
            if (hdr[12] && (hdr[11:10] == plc_pkg::OP_RD || hdr[11:10] == plc_pkg::OP_WR)) begin
              st_nxt.st = plc_pkg::PLC_TA;
              st_nxt.is_rd = hdr[11:10] == plc_pkg::OP_RD;
              st_nxt.hit = hdr[9:5] == PHY_ADDR && hdr[4:0] == plc_pkg::REG_ADDR;
            end else begin
              st_nxt.st = plc_pkg::PLC_PRE;
            end
          end else begin
            st_nxt.bcnt = st_r.bcnt + 5'h01;
          end
        end
        plc_pkg::PLC_TA: begin
          if (st_r.bcnt == 5'h00) begin
            st_nxt.bcnt = 5'h01;
            if (rd_pulse) begin
              // second turnaround bit driven low, data captured now
              st_nxt.oe = 1'b1;
              st_nxt.mdo = 1'b0;
              st_nxt.sh = rd_word;
            end
          end else begin
            st_nxt.bcnt = 5'h00;
            if (st_r.is_rd) begin
              st_nxt.st = plc_pkg::PLC_RDATA;
              st_nxt.mdo = st_r.hit & st_r.sh[15];
              st_nxt.sh = {st_r.sh[14:0], 1'b0};
            end else begin
              st_nxt.st = plc_pkg::PLC_WDATA;
            end
          end
        end
        plc_pkg::PLC_RDATA: begin
          if (st_r.bcnt == plc_pkg::DATA_LAST) begin
            st_nxt.oe = 1'b0;
            st_nxt.mdo = 1'b0;
            st_nxt.st = plc_pkg::PLC_PRE;
            st_nxt.bcnt = 5'h00;
          end else begin
            st_nxt.mdo = st_r.hit & st_r.sh[15];
            st_nxt.sh = {st_r.sh[14:0], 1'b0};
            st_nxt.bcnt = st_r.bcnt + 5'h01;
          end
        end
        plc_pkg::PLC_WDATA: begin
          st_nxt.sh = {st_r.sh[14:0], mdio_f};
          if (st_r.bcnt == plc_pkg::DATA_LAST) begin
            st_nxt.wr_stb = st_r.hit;
            st_nxt.st = plc_pkg::PLC_PRE;
            st_nxt.bcnt = 5'h00;
          end else begin
            st_nxt.bcnt = st_r.bcnt + 5'h01;
          end
        end
        default: begin
          st_nxt.st = plc_pkg::PLC_PRE;
          st_nxt.oe = 1'b0;
          st_nxt.mdo = 1'b0;
        end
      endcase
    end

    // register write; read-only and reserved positions are ignored
    if (st_r.wr_stb) begin
      st_nxt.pd_en = st_r.sh[plc_pkg::F_PD_EN];
      st_nxt.link_en = st_r.sh[plc_pkg::F_LINK_EN];
      st_nxt.att = st_r.sh[plc_pkg::F_ATT_HI:plc_pkg::F_ATT_LO];
      st_nxt.jab_dis = st_r.sh[plc_pkg::F_JABBER];
      st_nxt.hb_en = st_r.sh[plc_pkg::F_HEARTBEAT];
      st_nxt.tp_dis = st_r.sh[plc_pkg::F_TP_ECHO];
      st_nxt.pre = st_r.sh[plc_pkg::F_PRE_HI:plc_pkg::F_PRE_LO];
      st_nxt.force_irq = st_r.sh[plc_pkg::F_FORCE];
    end

    // latched high: a set in the read cycle survives the clear
    st_nxt.partner = partner_set | (st_r.partner & ~rd_pulse);

    // phone detection starts on each fall of link enable while pd_en is set
    st_nxt.pd_start = st_r.link_en & ~st_nxt.link_en & st_nxt.pd_en;
    if (st_nxt.pd_start) begin
      st_nxt.pd_active = 1'b1;
      st_nxt.phone_det = 1'b0;
    end else begin
      if (st_nxt.link_en || !st_nxt.pd_en) begin
        st_nxt.pd_active = 1'b0;
      end
      if (st_r.pd_active && phone_f) begin
        st_nxt.phone_det = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign u_dsif.attempts = st_r.att;
  assign u_dsif.mode = downshift_mode;
  assign u_dsif.neg_fail = neg_fail;
  assign u_dsif.link_lost = link_lost;
  assign u_dsif.link_enable = st_r.link_en;

  assign mdio_out = st_r.mdo;
  assign mdio_oe = st_r.oe;
  assign link_enable = st_r.link_en;
  assign link_pulse_watch = st_r.link_en;
  assign standby = ~st_r.link_en;
  assign cable_reflectometry_avail = ~st_r.link_en;
  assign phone_detect_start = st_r.pd_start;
  assign downshift_attempts = {1'b0, st_r.att} + 4'h1;
  assign speed_sel = u_dsif.speed;
  assign jabber_enable = ~st_r.jab_dis;
  assign heartbeat_enable = st_r.hb_en;
  assign twisted_pair_echo_disable = st_r.tp_dis;
  assign preamble_bytes = plc_pkg::pre_bytes(st_r.pre);
  // active-low pin, low for the forced bit or any pending interrupt
  assign mgmt_irq_n = ~(st_r.force_irq | irq_pending);

  chk_phone_gate: assert property (@(posedge clock) disable iff (reset)
    link_enable |-> !rd_word[plc_pkg::F_PHONE_DET])
    else $error("phone bit shown while linking on");

  chk_phone_start: assert property (@(posedge clock) disable iff (reset)
    ($fell(st_r.link_en) && st_r.pd_en) |-> phone_detect_start ##1 !phone_detect_start)
    else $error("phone detection not started on link disable");

  chk_link_on: assert property (@(posedge clock) disable iff (reset)
    (st_r.wr_stb && st_r.sh[plc_pkg::F_LINK_EN]) |=> link_pulse_watch && !standby)
    else $error("link enable write not applied");

  chk_link_off: assert property (@(posedge clock) disable iff (reset)
    (st_r.wr_stb && !st_r.sh[plc_pkg::F_LINK_EN])
    |=> standby && !link_pulse_watch && cable_reflectometry_avail)
    else $error("standby not entered on link disable");

  chk_attempts: assert property (@(posedge clock) disable iff (reset)
    st_r.wr_stb |=> downshift_attempts == {1'b0, $past(st_r.sh[12:10])} + 4'h1)
    else $error("attempt count not field plus one");

  chk_partner_set: assert property (@(posedge clock) disable iff (reset)
    partner_set |=> st_r.partner)
    else $error("partner bit not latched");

  chk_lh_hold: assert property (@(posedge clock) disable iff (reset)
    (st_r.partner && !rd_pulse) |=> st_r.partner)
    else $error("latched bit cleared without a read");

  chk_ten_ctrl: assert property (@(posedge clock) disable iff (reset)
    st_r.wr_stb |=> jabber_enable == !$past(st_r.sh[6]) && heartbeat_enable == $past(st_r.sh[5])
    && twisted_pair_echo_disable == $past(st_r.sh[4]))
    else $error("10 Mb/s control bits not applied");

  chk_preamble: assert property (@(posedge clock) disable iff (reset)
    st_r.pre == 2'h3 |-> preamble_bytes == 3'h7)
    else $error("long preamble code not seven bytes");

  chk_irq_force: assert property (@(posedge clock) disable iff (reset)
    (st_r.wr_stb && st_r.sh[plc_pkg::F_FORCE]) |=> !mgmt_irq_n)
    else $error("forced interrupt not driven low");

  chk_reserved: assert property (@(posedge clock) disable iff (reset)
    rd_pulse |=> st_r.sh[9:8] == 2'h0 && st_r.sh[1] == 1'b0)
    else $error("reserved bits read nonzero");

  chk_read_drive: assert property (@(posedge clock) disable iff (reset)
    rd_pulse |=> mdio_oe && !mdio_out)
    else $error("turnaround not driven low");
endmodule

/* tb/plc_smc.sv */
// station management controller model: makes mdc and drives the shared data line
// assumes the device drives the line only while its output enable is high
`timescale 1ns/1ps
module plc_smc (
  input wire logic clock,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_pin,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  logic drv_en;
  logic drv_bit;

  // pull-up holds the line high when nobody drives it
  assign mdio_pin = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'b1);

  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_bit = 1'b1;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end

  // one whole frame; mdc low and high for ten clocks each, still low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
    @(posedge clock);
    for (int i = 0; i < 64; i++) begin
      #1 mdc = 1'b0;
      drv_en = !(op == plc_pkg::OP_RD && i >= 46);
      drv_bit = f[63-i];
      repeat (10) @(posedge clock);
      #1;
      if (i >= 48) begin
        rd_data[63-i] = mdio_pin;
      end
      mdc = 1'b1;
      repeat (10) @(posedge clock);
    end
    #1 mdc = 1'b0;
    drv_en = 1'b0;
    if (op == plc_pkg::OP_RD) begin
      rd_valid = 1'b1;
      @(posedge clock);
      #1 rd_valid = 1'b0;
    end
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the link control register: frames, port decodes, downshift
// assumes plc_smc stands in for the management controller on the serial pins
`timescale 1ns/1ps
module tb;
  logic clock, reset, mdc, mdio_in, mdio_out, mdio_oe, rd_valid;
  logic phone_detect_in, partner_detect_in, irq_pending, neg_fail, link_lost;
  logic link_enable, standby, link_pulse_watch, phone_detect_start, cable_reflectometry_avail;
  logic jabber_enable, heartbeat_enable, twisted_pair_echo_disable, mgmt_irq_n;
  logic [1:0] downshift_mode, speed_sel;
  logic [3:0] downshift_attempts;
  logic [2:0] preamble_bytes;
  logic [15:0] rd_data, w;
  logic [15:0] expq[$];
  int n_mismatch = 0;
  int n_tests = 0;

  plc_top dut (.clock(clock), .reset(reset), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phone_detect_in(phone_detect_in),
    .partner_detect_in(partner_detect_in), .irq_pending(irq_pending), .neg_fail(neg_fail),
    .link_lost(link_lost), .downshift_mode(downshift_mode), .link_enable(link_enable),
    .standby(standby), .link_pulse_watch(link_pulse_watch),
    .phone_detect_start(phone_detect_start),
    .cable_reflectometry_avail(cable_reflectometry_avail),
    .downshift_attempts(downshift_attempts), .speed_sel(speed_sel),
    .jabber_enable(jabber_enable), .heartbeat_enable(heartbeat_enable),
    .twisted_pair_echo_disable(twisted_pair_echo_disable), .preamble_bytes(preamble_bytes),
    .mgmt_irq_n(mgmt_irq_n));
  plc_smc smc (.clock(clock), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_pin(mdio_in), .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read results are matched in order against the notes left by rd or pushed onto expq directly
  always @(posedge clock) begin
    if (rd_valid) begin
      chk("read data", expq.pop_front(), rd_data);
    end
  end

  task automatic wr(input logic [15:0] d);
    smc.xfer(plc_pkg::OP_WR, plc_pkg::PHY_ADDR_DFLT, plc_pkg::REG_ADDR, d);
    repeat (4) @(posedge clock);
  endtask

  task automatic rd(input logic [15:0] exp);
    expq.push_back(exp);
    smc.xfer(plc_pkg::OP_RD, plc_pkg::PHY_ADDR_DFLT, plc_pkg::REG_ADDR, 16'h0000);
  endtask

  task automatic ports(input logic [15:0] v);
    @(negedge clock);
    chk("link_enable", 16'(v[13]), 16'(link_enable));
    chk("link_pulse_watch", 16'(v[13]), 16'(link_pulse_watch));
    chk("standby", 16'(!v[13]), 16'(standby));
    chk("reflectometry", 16'(!v[13]), 16'(cable_reflectometry_avail));
    chk("attempts", 16'(v[12:10]) + 16'h0001, 16'(downshift_attempts));
    chk("jabber_enable", 16'(!v[6]), 16'(jabber_enable));
    chk("heartbeat", 16'(v[5]), 16'(heartbeat_enable));
    chk("echo_disable", 16'(v[4]), 16'(twisted_pair_echo_disable));
    chk("preamble", (v[3:2] == 2'h3) ? 16'h0007 : 16'(v[3:2]), 16'(preamble_bytes));
    chk("irq_n", 16'(!(v[0] || irq_pending)), 16'(mgmt_irq_n));
  endtask

  task automatic fails(input int n, input logic [1:0] exp);
    repeat (n) begin
      @(posedge clock);
      #1 neg_fail = 1'b1;
      @(posedge clock);
      #1 neg_fail = 1'b0;
      repeat (2) @(posedge clock);
    end
    @(negedge clock);
    chk("speed_sel", 16'(exp), 16'(speed_sel));
  endtask

  initial begin
    #900_000;
    n_mismatch++;
    $display("BAD watchdog expected finish seen hang");
    results();
  end

  initial begin
    reset = 1'b1;
    {phone_detect_in, partner_detect_in, irq_pending, neg_fail, link_lost} = 5'h00;
    downshift_mode = 2'b11;
    void'($urandom(32'h278b));
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    repeat (10) @(posedge clock);
    ports(16'h3048);
    rd(16'h3048);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      w = ($urandom() & 16'h7c7d) | 16'h2000;
      w[12:10] = i[2:0];
      w[3:2] = i[1:0];
      @(posedge clock);
      #1 irq_pending = 1'($urandom());
      wr(w | 16'h8382);
      ports(w);
      rd(w);
    end
    $display("test field decodes done");
    wr(16'h2400);
    fails(1, plc_pkg::PLC_SPD_1000);
    fails(1, plc_pkg::PLC_SPD_100);
    fails(2, plc_pkg::PLC_SPD_10);
    fails(2, plc_pkg::PLC_SPD_1000);
    fails(2, plc_pkg::PLC_SPD_100);
    @(posedge clock);
    #1 link_lost = 1'b1;
    @(posedge clock);
    #1 link_lost = 1'b0;
    downshift_mode = 2'b01;
    fails(0, plc_pkg::PLC_SPD_1000);
    fails(2, plc_pkg::PLC_SPD_10);
    @(posedge clock);
    #1 downshift_mode = 2'b11;
    fails(2, plc_pkg::PLC_SPD_1000);
    fails(2, plc_pkg::PLC_SPD_100);
    @(posedge clock);
    #1 downshift_mode = 2'b10;
    fails(2, plc_pkg::PLC_SPD_1000);
    fails(2, plc_pkg::PLC_SPD_100);
    $display("test downshift done");
    @(posedge clock);
    #1 phone_detect_in = 1'b1;
    partner_detect_in = 1'b1;
    wr(16'h6000);
    rd(16'h6000);
    partner_detect_in = 1'b0;
    fork
      wr(16'h4382);
      begin
        for (int k = 0; k < 2000 && link_enable !== 1'b0; k++) @(negedge clock);
        if (link_enable !== 1'b0) begin
          n_mismatch++;
          $display("BAD link_enable expected 0 seen %b", link_enable);
          results();
        end
        chk("phone_detect_start", 16'h0001, 16'(phone_detect_start));
      end
    join
    ports(16'h4000);
    chk("speed_sel", 16'h0000, 16'(speed_sel));
    @(posedge clock);
    #1 partner_detect_in = 1'b1;
    repeat (10) @(posedge clock);
    #1 partner_detect_in = 1'b0;
    repeat (10) @(posedge clock);
    rd(16'hc080);
    rd(16'hc000);
    $display("test standby detection done");
    smc.xfer(plc_pkg::OP_WR, 5'h02, plc_pkg::REG_ADDR, 16'h2000);
    smc.xfer(plc_pkg::OP_WR, plc_pkg::PHY_ADDR_DFLT, 5'h16, 16'h2000);
    repeat (4) @(posedge clock);
    rd(16'hc000);
    expq.push_back(16'hffff);
    smc.xfer(plc_pkg::OP_RD, 5'h02, plc_pkg::REG_ADDR, 16'h0000);
    $display("test foreign frames done");
    repeat (4) @(posedge clock);
    results();
  end
endmodule
